//--- include/octal_uart_pkg.sv
/*
 * shared constants for the octal line-mode and interrupt-scanner block:
 * register decode, field positions, reset values, scanner states.
 * assumes one system clock and a byte-wide register port.
 */
package octal_uart_pkg;
	localparam int         LINES          = 8;
	localparam int         RPT_WIDTH      = 4;
	localparam int         RPT_DEPTH      = 2;
	// register select on the low three address inputs
	localparam logic [2:0] SEL_COMMAND    = 3'h0;
	localparam logic [2:0] SEL_MODE1      = 3'h1;
	localparam logic [2:0] SEL_ISUMMARY   = 3'h2;
	localparam logic [2:0] SEL_DSCSUMMARY = 3'h3;
	localparam logic [2:0] SEL_RXBUFFER   = 3'h4;
	localparam logic [2:0] SEL_HOLDING    = 3'h5;
	// command and mode-1 register fields
	localparam int         CMD_MODE_HI    = 7;
	localparam int         CMD_MODE_LO    = 6;
	localparam int         CMD_RECEIVE_IRQ_ENABLE       = 5;
	localparam int         CMD_RECEIVE_ENABLE       = 2;
	localparam int         CMD_TRANSMIT_IRQ_ENABLE       = 1;
	localparam int         CMD_TRANSMIT_ENABLE       = 0;
	localparam int         MODE1_MODEM_IRQ_ENABLE     = 5;
	// interrupt summary fields
	localparam int         ISUM_IRQ       = 7;
	localparam int         ISUM_DIR       = 0;
	// operating_mode_field encodings
	localparam logic [1:0] MODE_NORMAL    = 2'h0;
	localparam logic [1:0] MODE_ECHO      = 2'h1;
	localparam logic [1:0] MODE_LOCAL     = 2'h2;
	localparam logic [1:0] MODE_REMOTE    = 2'h3;
	// reset values and post-reset warm-up count
	localparam logic [7:0] CMD_RESET      = 8'h00;
	localparam logic [3:0] SCAN_RESET     = 4'h0;
	localparam logic [1:0] WARM_CYCLES    = 2'h3;
	typedef enum logic [1:0] {
		SCAN = 2'b01,
		HALT = 2'b10
	} scan_t;
endpackage : octal_uart_pkg

//--- rtl/octal_uart_modes_irq_scanner.sv
/*
 * line routing per operating mode, status gating, data-set-change
 * summary and the shared interrupt scanner of an eight-line uart.
 * assumes character engines outside: they take RX_SER/enables and
 * report ready/idle flags; the host port is strobed on CLK.
 */
// Operation
// [R1] two-bit mode per line: normal, echo, local, remote; reset gives normal.
// [R2] normal: receive needs receive_enable, transmit needs transmit_enable.
// [R3] echo: input forwarded out, transmitter off, tx flags and tx interrupts cleared.
// [R4] local loopback: input pin ignored, tx serial feeds receiver, output held high.
// [R5] local loopback keeps the configured transmit and receive speeds.
// [R6] remote: input copied to output, no characters, flags off, enables cleared.
// [R7] summary registers decoded by low three address bits only.
// [R8] summary bit 7 mirrors active request; bits 6 to 4 read zero.
// [R9] summary bits 3 to 1 line number, bit 0 one for transmitter.
// [R10] summary bits 3 to 0 are the free-running scanner count; the code reorders them as in [R9].
// [R11] modem interrupts need modem_irq_enable and receive_irq_enable with data_set_change.
// [R12] data-set-change bit cleared by writing one; zero leaves it.
// [R13] software reads then writes back the summary with interrupts off.
// [R14] reset initialises change logic; later input changes are recorded; the code also sets the bit of a modem input held low through reset.
// [R15] four-bit scanner: 0-7 receivers, 8-15 transmitters, lines in order.
// [R16] found condition stops scanner and drives request low until serviced; with the report buffer full the code parks the scanner, request high.
// [R17] receiver condition: ready with irq enable, or change with both enables.
// [R18] transmitter condition: transmit_ready with transmit_irq_enable.
// [R19] stopped scanner drives line number and direction outputs and summary.
// [R20] request released when the causing condition is cleared or serviced.
// [R21] receiver stop resumes in place; transmitter stop restarts at zero.
// [R22] host uses level-sensitive request when modem interrupts are on.
// [R23] transmit_ready means holding empty; transmitter_empty needs serializer idle too.
// [R24] scanner advances one position per clock while nothing found, wrapping.
`timescale 1ns/1ps
module octal_uart_modes_irq_scanner (
	input  wire logic                               CLK,
	input  wire logic                               RST,
	input  wire logic                               CS,
	input  wire logic                               RD,
	input  wire logic                               WR,
	input  wire logic [5:0]                         ADDR,
	input  wire logic [7:0]                         DIN,
	output logic      [7:0]                         DOUT,
	input  wire logic [octal_uart_pkg::LINES-1:0]   SERIAL_INPUT,
	output logic      [octal_uart_pkg::LINES-1:0]   SERIAL_OUTPUT,
	input  wire logic [octal_uart_pkg::LINES-1:0]   DSR_N,
	input  wire logic [octal_uart_pkg::LINES-1:0]   DCD_N,
	input  wire logic [octal_uart_pkg::LINES-1:0]   TX_SER,
	output logic      [octal_uart_pkg::LINES-1:0]   RX_SER,
	output logic      [octal_uart_pkg::LINES-1:0]   RX_ENABLE,
	output logic      [octal_uart_pkg::LINES-1:0]   TX_ENABLE,
	input  wire logic [octal_uart_pkg::LINES-1:0]   RX_READY_IN,
	input  wire logic [octal_uart_pkg::LINES-1:0]   TX_READY_IN,
	input  wire logic [octal_uart_pkg::LINES-1:0]   TX_IDLE_IN,
	output logic      [octal_uart_pkg::LINES-1:0]   RECEIVE_READY,
	output logic      [octal_uart_pkg::LINES-1:0]   TRANSMIT_READY,
	output logic      [octal_uart_pkg::LINES-1:0]   TRANSMITTER_EMPTY,
	output logic      [octal_uart_pkg::LINES-1:0]   RXBUF_READ,
	output logic      [octal_uart_pkg::LINES-1:0]   HOLDING_LOAD,
	output logic      [7:0]                         HOLDING_DATA,
	output logic                                    IRQ_N,
	output logic      [2:0]                         INTERRUPT_LINE_OUTPUTS,
	output logic                                    INTERRUPT_DIRECTION,
	output logic                                    REPORT_VALID,
	input  wire logic                               REPORT_READY,
	output logic      [octal_uart_pkg::RPT_WIDTH-1:0] REPORT_DATA
);
	import octal_uart_pkg::*;

	logic [7:0]       cmd_r [LINES];
	logic [LINES-1:0] modem_irq_enable_r;
	logic [LINES-1:0] dsc_r;
	logic [LINES-1:0] sin_s1_r, sin_s2_r, sin_s3_r, sin_r;
	logic [LINES-1:0] dsr_s1_r, dsr_s2_r, dsr_s3_r, dsr_r, dsr_old_r;
	logic [LINES-1:0] dcd_s1_r, dcd_s2_r, dcd_s3_r, dcd_r, dcd_old_r;
	logic [1:0]       warm_r;
	logic [3:0]       pos_r;
	scan_t            state_r;
	logic [LINES-1:0] rx_en, tx_en, rx_rdy, tx_rdy, rx_cond, tx_cond;
	logic             cond, rpt_ready, hit, release_now;
	logic [2:0]       line_sel;
	logic             rd_en, wr_en;

	// a pin change counts only when stages two and three agree
	function automatic logic [LINES-1:0] settle(input logic [LINES-1:0] held,
		input logic [LINES-1:0] s2, input logic [LINES-1:0] s3);
		settle = (~(s2 ^ s3) & s2) | ((s2 ^ s3) & held);
	endfunction : settle

	function automatic logic [1:0] mode_of(input logic [7:0] c);
		mode_of = c[CMD_MODE_HI:CMD_MODE_LO];
	endfunction : mode_of

	assign line_sel = ADDR[5:3];
	assign rd_en    = CS && RD;
	assign wr_en    = CS && WR;

	////////////////////////////////////////////////////////////////////////
	// pin synchronisers
	always_ff @(posedge CLK or posedge RST)
	begin
		if (RST)
		begin
			sin_s1_r <= '1;
			sin_s2_r <= '1;
			sin_s3_r <= '1;
			sin_r <= '1;
			dsr_s1_r <= '1;
			dsr_s2_r <= '1;
			dsr_s3_r <= '1;
			dsr_r <= '1;
			dcd_s1_r <= '1;
			dcd_s2_r <= '1;
			dcd_s3_r <= '1;
			dcd_r <= '1;
		end
		else
		begin
			sin_s1_r <= SERIAL_INPUT;
			sin_s2_r <= sin_s1_r;
			sin_s3_r <= sin_s2_r;
			sin_r <= settle(sin_r, sin_s2_r, sin_s3_r);
			dsr_s1_r <= DSR_N;
			dsr_s2_r <= dsr_s1_r;
			dsr_s3_r <= dsr_s2_r;
			dsr_r <= settle(dsr_r, dsr_s2_r, dsr_s3_r);
			dcd_s1_r <= DCD_N;
			dcd_s2_r <= dcd_s1_r;
			dcd_s3_r <= dcd_s2_r;
			dcd_r <= settle(dcd_r, dcd_s2_r, dcd_s3_r);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// command and mode-1 registers; remote loopback holds both enables low
	always_ff @(posedge CLK or posedge RST)
	begin
		if (RST)
		begin
			for (int i = 0; i < LINES; i++)
				cmd_r[i] <= CMD_RESET; // [R1]
			modem_irq_enable_r <= '0;
		end
		else
		begin
			if (wr_en && ADDR[2:0] == SEL_COMMAND)
				cmd_r[line_sel] <= DIN & 8'he7; // break and error-reset live elsewhere
			if (wr_en && ADDR[2:0] == SEL_MODE1)
				modem_irq_enable_r[line_sel] <= DIN[MODE1_MODEM_IRQ_ENABLE];
			// a same-cycle rewrite of this line's command must not lose its enables
			for (int i = 0; i < LINES; i++)
				if (mode_of(cmd_r[i]) == MODE_REMOTE && !(wr_en && ADDR[2:0] == SEL_COMMAND && line_sel == 3'(i)))
				begin
					cmd_r[i][CMD_RECEIVE_ENABLE] <= 1'b0; // [R6]
					cmd_r[i][CMD_TRANSMIT_ENABLE] <= 1'b0; // [R6]
				end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// effective enables, gated flags and scanner conditions
	always_comb
	begin
		for (int i = 0; i < LINES; i++)
		begin
			// [R2] echo and remote never let the transmitter run
			rx_en[i] = cmd_r[i][CMD_RECEIVE_ENABLE] && mode_of(cmd_r[i]) != MODE_REMOTE; // [R6]
			tx_en[i] = cmd_r[i][CMD_TRANSMIT_ENABLE] && !cmd_r[i][CMD_MODE_LO]; // [R3]
			rx_rdy[i] = RX_READY_IN[i] && rx_en[i];
			tx_rdy[i] = TX_READY_IN[i] && tx_en[i]; // [R23]
			rx_cond[i] = cmd_r[i][CMD_RECEIVE_IRQ_ENABLE] && (rx_rdy[i] || (dsc_r[i] && modem_irq_enable_r[i])); // [R17] [R11]
			tx_cond[i] = tx_rdy[i] && cmd_r[i][CMD_TRANSMIT_IRQ_ENABLE]; // [R18] [R3]
		end
	end

	// serial routing; the engines keep their own speed settings in every mode
	always_ff @(posedge CLK or posedge RST)
	begin
		if (RST)
		begin
			SERIAL_OUTPUT <= '1;
			RX_SER <= '1;
		end
		else
		begin
			for (int i = 0; i < LINES; i++)
			begin
				unique case (mode_of(cmd_r[i])) // [R1] [R5]
					MODE_NORMAL:
					begin
						SERIAL_OUTPUT[i] <= TX_SER[i];
						RX_SER[i] <= sin_r[i];
					end
					MODE_ECHO:
					begin
						SERIAL_OUTPUT[i] <= sin_r[i]; // [R3]
						RX_SER[i] <= sin_r[i];
					end
					MODE_LOCAL:
					begin
						SERIAL_OUTPUT[i] <= 1'b1; // [R4]
						RX_SER[i] <= TX_SER[i]; // [R4]
					end
					MODE_REMOTE:
					begin
						SERIAL_OUTPUT[i] <= sin_r[i]; // [R6]
						RX_SER[i] <= 1'b1;
					end
				endcase
			end
		end
	end

	// registered status toward the engines and the status register
	always_ff @(posedge CLK or posedge RST)
	begin
		if (RST)
		begin
			RX_ENABLE <= '0;
			TX_ENABLE <= '0;
			RECEIVE_READY <= '0;
			TRANSMIT_READY <= '0;
			TRANSMITTER_EMPTY <= '0;
		end
		else
		begin
			RX_ENABLE <= rx_en; // [R2]
			TX_ENABLE <= tx_en; // [R2]
			RECEIVE_READY <= rx_rdy;
			TRANSMIT_READY <= tx_rdy;
			TRANSMITTER_EMPTY <= tx_rdy & TX_IDLE_IN; // [R23]
		end
	end

	////////////////////////////////////////////////////////////////////////
	// data-set-change summary; the three-cycle warm-up ends before a modem input held low
	// through reset has settled, so such a line still records a change after reset
	always_ff @(posedge CLK or posedge RST)
	begin
		if (RST)
		begin
			warm_r <= '0; // [R14]
			dsc_r <= '0;
			dsr_old_r <= '1;
			dcd_old_r <= '1;
		end
		else
		begin
			if (warm_r != WARM_CYCLES)
				warm_r <= warm_r + 2'h1;
			dsr_old_r <= dsr_r;
			dcd_old_r <= dcd_r;
			// set wins over a same-cycle write-one clear
			dsc_r <= (dsc_r & ~((wr_en && ADDR[2:0] == SEL_DSCSUMMARY) ? DIN : 8'h00)) // [R12]
				| (((dsr_r ^ dsr_old_r) | (dcd_r ^ dcd_old_r)) & {LINES{warm_r == WARM_CYCLES}}); // [R14]
		end
	end

	////////////////////////////////////////////////////////////////////////
	// interrupt scanner
	assign cond        = pos_r[3] ? tx_cond[pos_r[2:0]] : rx_cond[pos_r[2:0]]; // [R15]
	assign hit         = state_r == SCAN && cond && rpt_ready;
	assign release_now = state_r == HALT && !cond; // [R20]

	// a full report buffer parks the scanner on the hit rather than losing it
	always_ff @(posedge CLK or posedge RST)
	begin
		if (RST)
		begin
			state_r <= SCAN;
			pos_r <= SCAN_RESET;
		end
		else
		begin
			unique case (state_r)
				SCAN:
				begin
					if (hit)
						state_r <= HALT; // [R16]
					else if (!cond)
						pos_r <= pos_r + 4'h1; // [R24]
				end
				HALT:
				begin
					if (!cond)
					begin
						state_r <= SCAN;
						pos_r <= pos_r[3] ? SCAN_RESET : pos_r; // [R21]
					end
				end
			endcase
		end
	end

	// request and vector pins, registered with the stop decision
	always_ff @(posedge CLK or posedge RST)
	begin
		if (RST)
		begin
			IRQ_N <= 1'b1;
			INTERRUPT_LINE_OUTPUTS <= '0;
			INTERRUPT_DIRECTION <= 1'b0;
		end
		else
		begin
			if (hit)
			begin
				IRQ_N <= 1'b0; // [R16]
				INTERRUPT_LINE_OUTPUTS <= pos_r[2:0]; // [R19]
				INTERRUPT_DIRECTION <= pos_r[3]; // [R19]
			end
			else if (release_now)
				IRQ_N <= 1'b1; // [R20]
		end
	end

	report_buffer u_reports (
		.CLK       (CLK),
		.RST       (RST),
		.in_valid  (hit),
		.in_ready  (rpt_ready),
		.in_data   (pos_r),
		.out_valid (REPORT_VALID),
		.out_ready (REPORT_READY),
		.out_data  (REPORT_DATA)
	);

	////////////////////////////////////////////////////////////////////////
	// register reads and buffer strobes; summaries ignore the line bits
	always_ff @(posedge CLK or posedge RST)
	begin
		if (RST)
		begin
			DOUT <= 8'h00;
			RXBUF_READ <= '0;
			HOLDING_LOAD <= '0;
			HOLDING_DATA <= 8'h00;
		end
		else
		begin
			RXBUF_READ <= '0;
			HOLDING_LOAD <= '0;
			if (rd_en)
			begin
				unique case (ADDR[2:0]) // [R7]
					SEL_COMMAND:    DOUT <= cmd_r[line_sel];
					SEL_MODE1:      DOUT <= 8'(modem_irq_enable_r[line_sel]) << MODE1_MODEM_IRQ_ENABLE;
					// counter bits reordered: line number above, direction in bit 0
					SEL_ISUMMARY:   DOUT <= {state_r == HALT, 3'h0, pos_r[2:0], pos_r[3]}; // [R8] [R9] [R10]
					SEL_DSCSUMMARY: DOUT <= dsc_r;
					default:        DOUT <= 8'h00;
				endcase
				if (ADDR[2:0] == SEL_RXBUFFER)
					RXBUF_READ[line_sel] <= 1'b1;
			end
			if (wr_en && ADDR[2:0] == SEL_HOLDING)
			begin
				HOLDING_LOAD[line_sel] <= 1'b1;
				HOLDING_DATA <= DIN;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge CLK); endclocking
	default disable iff (RST);

	sequence s_stop;
		hit;
	endsequence
	sequence s_low_then_release;
		(!IRQ_N && state_r == HALT) [*1] ##0 release_now;
	endsequence

	a_irq_on_stop: assert property (s_stop |=> !IRQ_N && state_r == HALT) // [R16]
		else $error("request not raised on stop");
	a_irq_release: assert property (s_low_then_release |=> IRQ_N && state_r == SCAN) // [R20]
		else $error("request not released");
	a_tx_restart: assert property (release_now && pos_r[3] |=> pos_r == 4'h0) // [R21]
		else $error("transmitter stop did not restart at zero");
	a_rx_resume: assert property (release_now && !pos_r[3] |=> pos_r == $past(pos_r)) // [R21]
		else $error("receiver stop did not resume in place");
	a_scan_step: assert property (state_r == SCAN && !cond |=> pos_r == 4'($past(pos_r) + 4'h1)) // [R24]
		else $error("scanner did not advance");
	a_vec_pins: assert property (s_stop |=> {INTERRUPT_DIRECTION, INTERRUPT_LINE_OUTPUTS} == pos_r) // [R19]
		else $error("vector pins disagree with stop position");
	a_summary_bits: assert property (rd_en && ADDR[2:0] == SEL_ISUMMARY |=> DOUT[6:4] == 3'h0 // [R8]
		&& DOUT[ISUM_IRQ] == $past(state_r == HALT))
		else $error("summary read wrong");
	// line 3 is the one the mode tests walk through every mode
	a_local_high: assert property (mode_of(cmd_r[3]) == MODE_LOCAL |=> SERIAL_OUTPUT[3]) // [R4]
		else $error("local loopback output not high");
	a_echo_copy: assert property (mode_of(cmd_r[3]) == MODE_ECHO |=> SERIAL_OUTPUT[3] == $past(sin_r[3]) // [R3]
		&& !TRANSMIT_READY[3])
		else $error("echo routing wrong");
	a_remote_off: assert property (mode_of(cmd_r[3]) == MODE_REMOTE |=> !RX_ENABLE[3] && !RECEIVE_READY[3]) // [R6]
		else $error("remote loopback left receiver on");
	a_dsc_clear: assert property (wr_en && ADDR[2:0] == SEL_DSCSUMMARY && DIN[1] && dsr_r[1] == dsr_old_r[1] // [R12]
		&& dcd_r[1] == dcd_old_r[1] |=> !dsc_r[1])
		else $error("change bit not cleared by write of one");
endmodule : octal_uart_modes_irq_scanner

//--- rtl/report_buffer.sv
/*
 * two-entry buffer for scanner reports, valid/ready on both sides.
 * assumes both sides on CLK; flags are registered.
 */
`timescale 1ns/1ps
module report_buffer #(
	parameter int W = octal_uart_pkg::RPT_WIDTH,
	parameter int D = octal_uart_pkg::RPT_DEPTH
) (
	input  wire logic         CLK,
	input  wire logic         RST,
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic      [W-1:0] out_data
);
	import octal_uart_pkg::*;
	localparam int PW = (D > 1) ? $clog2(D) : 1;
	logic [W-1:0] mem_r [D];
	logic [PW-1:0] wp_r;
	logic [PW-1:0] rp_r;
	logic [PW:0]   cnt_r;
	logic [PW:0]   cnt_nxt;
	logic          push;
	logic          pop;

	function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
		bump = (p == PW'(D - 1)) ? '0 : p + 1'b1;
	endfunction : bump

	assign push     = in_valid && in_ready;
	assign pop      = out_valid && out_ready;
	assign out_data = mem_r[rp_r];
	assign cnt_nxt  = cnt_r + (PW+1)'(push) - (PW+1)'(pop);

	// storage and pointers
	always_ff @(posedge CLK or posedge RST)
	begin
		if (RST)
		begin
			wp_r <= '0;
			rp_r <= '0;
			cnt_r <= '0;
			for (int i = 0; i < D; i++)
				mem_r[i] <= '0;
		end
		else
		begin
			if (push)
			begin
				mem_r[wp_r] <= in_data;
				wp_r <= bump(wp_r);
			end
			if (pop)
				rp_r <= bump(rp_r);
			cnt_r <= cnt_nxt;
		end
	end

	// registered flags so a full buffer stalls the writer honestly
	always_ff @(posedge CLK or posedge RST)
	begin
		if (RST)
		begin
			in_ready <= 1'b1;
			out_valid <= 1'b0;
		end
		else
		begin
			in_ready <= (cnt_nxt != (PW+1)'(D));
			out_valid <= (cnt_nxt != '0);
		end
	end
endmodule : report_buffer

//--- verification/engine_model.sv
/*
 * engine model: stands in for the per-line character engines.
 * assumes CLK shared with the block and one-cycle strobes.
 */
`timescale 1ns/1ps
module engine_model (
	input  wire logic       CLK,
	input  wire logic       RST,
	input  wire logic [7:0] RX_ENABLE,
	input  wire logic [7:0] TX_ENABLE,
	input  wire logic [7:0] RXBUF_READ,
	input  wire logic [7:0] HOLDING_LOAD,
	input  wire logic [7:0] ARM_RX,
	input  wire logic [7:0] TX_DRIVE,
	output logic      [7:0] RX_READY_IN,
	output logic      [7:0] TX_READY_IN,
	output logic      [7:0] TX_IDLE_IN,
	output logic      [7:0] TX_SER
);
	int busy[8];
	// a character sits 20 cycles in holding, then 20 in the serializer
	always_ff @(posedge CLK or posedge RST)
	begin
		if (RST)
		begin
			RX_READY_IN <= 8'h00;
			TX_READY_IN <= 8'hff;
			TX_IDLE_IN  <= 8'hff;
			foreach (busy[i]) busy[i] <= 0;
		end
		else
		begin
			RX_READY_IN <= (RX_READY_IN | (ARM_RX & RX_ENABLE)) & ~RXBUF_READ;
			foreach (busy[i])
			begin
				if (HOLDING_LOAD[i]) busy[i] <= 40;
				else if (busy[i] > 0) busy[i] <= busy[i] - 1;
				TX_READY_IN[i] <= !HOLDING_LOAD[i] && busy[i] <= 21; // holding frees first
				TX_IDLE_IN[i]  <= !HOLDING_LOAD[i] && busy[i] <= 1;
			end
		end
	end
	// a disabled transmitter idles high, never a stale bit
	assign TX_SER = TX_DRIVE | ~TX_ENABLE;
endmodule : engine_model

//--- verification/testbench.sv
/*
 * self-checking bench for the line-mode and interrupt-scanner block.
 * assumes engine_model beside it and octal_uart_pkg compiled first.
 */
`timescale 1ns/1ps
module testbench;
	import octal_uart_pkg::*;
	logic        CLK, RST, CS, RD, WR, IRQ_N, INTERRUPT_DIRECTION, REPORT_VALID, REPORT_READY;
	logic [5:0]  ADDR;
	logic [2:0]  INTERRUPT_LINE_OUTPUTS;
	logic [3:0]  REPORT_DATA;
	logic [7:0]  DIN, DOUT, SERIAL_INPUT, SERIAL_OUTPUT, DSR_N, DCD_N, TX_SER, RX_SER, RX_ENABLE, TX_ENABLE;
	logic [7:0]  RX_READY_IN, TX_READY_IN, TX_IDLE_IN, RECEIVE_READY, TRANSMIT_READY, TRANSMITTER_EMPTY;
	logic [7:0]  RXBUF_READ, HOLDING_LOAD, HOLDING_DATA, arm_rx, tx_drive, d;
	logic [31:0] seed;
	logic [3:0]  exp_q[$];
	int          fails, checks_done, cycles, m;
	octal_uart_modes_irq_scanner octal_uart_modes_irq_scanner_i (.CLK(CLK), .RST(RST), .CS(CS), .RD(RD),
		.WR(WR), .ADDR(ADDR), .DIN(DIN), .DOUT(DOUT), .SERIAL_INPUT(SERIAL_INPUT), .SERIAL_OUTPUT(SERIAL_OUTPUT),
		.DSR_N(DSR_N), .DCD_N(DCD_N), .TX_SER(TX_SER), .RX_SER(RX_SER), .RX_ENABLE(RX_ENABLE),
		.TX_ENABLE(TX_ENABLE), .RX_READY_IN(RX_READY_IN), .TX_READY_IN(TX_READY_IN), .TX_IDLE_IN(TX_IDLE_IN),
		.RECEIVE_READY(RECEIVE_READY), .TRANSMIT_READY(TRANSMIT_READY), .TRANSMITTER_EMPTY(TRANSMITTER_EMPTY),
		.RXBUF_READ(RXBUF_READ), .HOLDING_LOAD(HOLDING_LOAD), .HOLDING_DATA(HOLDING_DATA), .IRQ_N(IRQ_N),
		.INTERRUPT_LINE_OUTPUTS(INTERRUPT_LINE_OUTPUTS), .INTERRUPT_DIRECTION(INTERRUPT_DIRECTION),
		.REPORT_VALID(REPORT_VALID), .REPORT_READY(REPORT_READY), .REPORT_DATA(REPORT_DATA));
	engine_model engine_model_i (.CLK(CLK), .RST(RST), .RX_ENABLE(RX_ENABLE), .TX_ENABLE(TX_ENABLE),
		.RXBUF_READ(RXBUF_READ), .HOLDING_LOAD(HOLDING_LOAD), .ARM_RX(arm_rx), .TX_DRIVE(tx_drive),
		.RX_READY_IN(RX_READY_IN), .TX_READY_IN(TX_READY_IN), .TX_IDLE_IN(TX_IDLE_IN), .TX_SER(TX_SER));
	////////////////////////////////////////////////////////////////
	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : xs
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			fails++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	task automatic wrap_up();
		$display("checks %0d fails %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : wrap_up
	// every drive lands 1 ns after a rising edge
	task automatic tick(input int n);
		repeat (n) @(posedge CLK);
		#1;
	endtask : tick
	task automatic acc(input logic w, input logic [5:0] a, input logic [7:0] v);
		CS = 1;
		RD = !w;
		WR = w;
		ADDR = a;
		DIN = v;
		tick(1);
		CS = 0;
		RD = 0;
		WR = 0;
		tick(1);
	endtask : acc
	task automatic arm(input logic [7:0] v);
		arm_rx = v;
		tick(1);
		arm_rx = 0;
	endtask : arm
	// request is level: poll it rather than wait for an edge
	task automatic wait_irq(input logic lvl);
		int n;
		for (n = 0; n < 100 && IRQ_N !== lvl; n++) tick(1);
		chk(n < 100, 1);
	endtask : wait_irq
	task automatic hit(input logic [2:0] ln, input logic dir);
		wait_irq(0);
		chk({INTERRUPT_LINE_OUTPUTS, INTERRUPT_DIRECTION}, {ln, dir});
		exp_q.push_back({dir, ln});
		acc(0, {3'(xs()), SEL_ISUMMARY}, 0);
		chk(DOUT, {4'h8, ln, dir});
	endtask : hit
	// take reports until the model queue is empty
	task automatic drain();
		REPORT_READY = 1;
		for (int n = 0; n < 20 && exp_q.size() > 0; n++)
		begin
			if (REPORT_VALID === 1'b1)
				chk(REPORT_DATA, exp_q.pop_front());
			tick(1);
		end
		chk(exp_q.size(), 0);
		REPORT_READY = 0;
	endtask : drain
	////////////////////////////////////////////////////////////////
	initial
	begin
		CLK = 0;
		forever #4 CLK = ~CLK;
	end
	// hang guard, well above the few hundred cycles the tests need
	always @(posedge CLK)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			fails++;
			wrap_up();
		end
	end
	initial
	begin
		seed = 32'h0608;
		{CS, RD, WR, ADDR, DIN, REPORT_READY, arm_rx, tx_drive} = 0;
		{SERIAL_INPUT, DSR_N, DCD_N} = 24'hffffff;
		RST = 1;
		repeat (20) @(posedge CLK);
		#1;
		RST = 0;
		tick(4);
		acc(0, {3'h5, SEL_ISUMMARY}, 0);
		chk(DOUT & 8'hf0, 0);
		acc(0, {3'h1, 3'h6}, 0);
		chk(DOUT, 0);
		acc(0, {3'h2, SEL_DSCSUMMARY}, 0);
		chk(DOUT, 0);
		chk(IRQ_N, 1);
		$display("test reset done");
		// routing of line 3 under every mode, random pin values
		for (int k = 0; k < 8; k++)
		begin
			m = k & 3;
			acc(1, {3'h3, SEL_COMMAND}, {2'(m), 6'h05});
			SERIAL_INPUT = 8'(xs());
			tx_drive = 8'(xs());
			tick(12);
			d = SERIAL_INPUT;
			chk(SERIAL_OUTPUT[3], m == 0 ? tx_drive[3] : m == 2 ? 1'b1 : d[3]);
			chk(RX_SER[3], m < 2 ? d[3] : m == 2 ? tx_drive[3] : 1'b1);
			chk(TX_ENABLE[3], m == 0 || m == 2);
			chk(RX_ENABLE[3], m != 3);
			chk({TRANSMIT_READY[3], TRANSMITTER_EMPTY[3]}, (m == 0 || m == 2) ? 3 : 0);
		end
		$display("test modes done");
		acc(1, {3'h2, SEL_COMMAND}, 8'h24);
		acc(1, {3'h5, SEL_COMMAND}, 8'h24);
		arm(8'h04);
		hit(2, 0);
		chk(RECEIVE_READY[2], 1);
		arm(8'h20);
		tick(20);
		chk(IRQ_N, 0);
		acc(0, {3'h2, SEL_RXBUFFER}, 0);
		wait_irq(1);
		chk(RECEIVE_READY[2], 0);
		hit(5, 0);
		acc(0, {3'h5, SEL_RXBUFFER}, 0);
		arm(8'h04);
		wait_irq(1);
		tick(30);
		chk(IRQ_N, 1);
		drain();
		hit(2, 0);
		acc(1, {3'h2, SEL_COMMAND}, 8'h04);
		wait_irq(1);
		drain();
		$display("test receive done");
		acc(1, {3'h0, SEL_COMMAND}, 8'h03);
		hit(0, 1);
		acc(1, {3'h6, SEL_COMMAND}, 8'h24);
		arm(8'h40);
		acc(1, {3'h4, SEL_COMMAND}, 8'h03);
		acc(1, {3'h0, SEL_HOLDING}, 8'ha5);
		wait_irq(1);
		hit(6, 0);
		acc(1, {3'h0, SEL_COMMAND}, 8'h01);
		acc(0, {3'h6, SEL_RXBUFFER}, 0);
		wait_irq(1);
		drain();
		hit(4, 1);
		acc(1, {3'h4, SEL_COMMAND}, 8'h01);
		wait_irq(1);
		drain();
		$display("test transmit done");
		acc(1, {3'h1, SEL_COMMAND}, 8'h24);
		acc(1, {3'h1, SEL_MODE1}, 8'h20);
		acc(1, {3'h4, SEL_COMMAND}, 8'h24);
		DCD_N[4] = 0;
		tick(20);
		chk(IRQ_N, 1);
		DSR_N[1] = 0;
		hit(1, 0);
		acc(1, {3'h0, SEL_DSCSUMMARY}, 8'h00);
		acc(0, {3'h7, SEL_DSCSUMMARY}, 0);
		chk(DOUT, 8'h12);
		acc(1, {3'h5, SEL_DSCSUMMARY}, DOUT);
		wait_irq(1);
		acc(0, {3'h3, SEL_DSCSUMMARY}, 0);
		chk(DOUT, 0);
		drain();
		$display("test modem done");
		acc(1, {3'h7, SEL_COMMAND}, 8'h01);
		d = 8'(xs());
		CS = 1;
		WR = 1;
		ADDR = {3'h7, SEL_HOLDING};
		DIN = d;
		tick(1);
		chk({HOLDING_LOAD, HOLDING_DATA}, {8'h80, d});
		// back-to-back receive buffer read: its strobe stands one cycle
		WR = 0;
		RD = 1;
		ADDR = {3'h7, SEL_RXBUFFER};
		tick(1);
		CS = 0;
		RD = 0;
		chk({RXBUF_READ, HOLDING_LOAD}, 16'h8000);
		tick(8);
		chk({TRANSMIT_READY[7], TRANSMITTER_EMPTY[7]}, 0);
		tick(25);
		chk({TRANSMIT_READY[7], TRANSMITTER_EMPTY[7]}, 2);
		tick(20);
		chk({TRANSMIT_READY[7], TRANSMITTER_EMPTY[7]}, 3);
		$display("test empty done");
		wrap_up();
	end
endmodule : testbench
